// *** verilog/nand_lock_pkg.sv ***
// Purpose: Shared constants and types for the NAND block-lock host
// Assumes: 25 MHz clock, 8-bit I/O bus, 16-bit block addresses
// Notes:   Times are kept in their own units; cycle counts derive from them
package nand_lock_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IO_W   = 8;
  localparam int BLK_W  = 16;
  localparam int STEP_W = 3;
  localparam int CNT_W  = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int POWER_WAIT_US  = 10;
  localparam int WP_PULSE_NS    = 100;
  localparam int BUSY_GAP_NS    = 100;
  localparam int READ_ACCESS_NS = 80;
  // Least times round up to whole cycles
  localparam int POWER_WAIT_CYC =
    (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_PULSE_CYC =
    (WP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_GAP_CYC =
    (BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Access time plus two synchroniser stages
  localparam int READ_WAIT_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [IO_W-1:0] CMD_LOCK         = 8'h2A;
  localparam logic [IO_W-1:0] CMD_UNLOCK_START = 8'h23;
  localparam logic [IO_W-1:0] CMD_UNLOCK_END   = 8'h24;
  localparam logic [IO_W-1:0] CMD_LOCK_TIGHT   = 8'h2C;
  localparam logic [IO_W-1:0] CMD_LOCK_STATUS  = 8'h7A;
  localparam logic [IO_W-1:0] CMD_STATUS       = 8'h70;
  localparam logic [IO_W-1:0] CMD_RESET        = 8'hFF;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic            PIN_INACTIVE   = 1'b1;
  localparam logic            WP_RESET_VAL   = 1'b0;
  localparam logic [IO_W-1:0] DATA_RESET_VAL = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET_VAL = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_LOCK,
    OP_UNLOCK,
    OP_LOCK_TIGHT,
    OP_LOCK_STATUS,
    OP_STATUS_AGAIN,
    OP_STATUS,
    OP_WP_PULSE,
    OP_RESET
  } op_t;

  typedef enum logic [1:0] {
    CYC_CMD,
    CYC_ADDR,
    CYC_READ
  } cycle_kind_t;

  typedef struct packed {
    cycle_kind_t     kind;
    logic [IO_W-1:0] data;
    logic            last;
  } step_t;

endpackage

// *** verilog/nand_cycle_if.sv ***
// Purpose: Request and answer of one NAND bus cycle
// Assumes: Single clock domain
// Notes:   req is a one-cycle pulse; done answers it once
`timescale 1ns/1ps
interface nand_cycle_if;
  logic                            req;
  nand_lock_pkg::cycle_kind_t      kind;
  logic [nand_lock_pkg::IO_W-1:0]  wdata;
  logic                            done;
  logic [nand_lock_pkg::IO_W-1:0]  rdata;

  modport issuer (output req, output kind, output wdata,
                  input done, input rdata);
  modport engine (input req, input kind, input wdata,
                  output done, output rdata);
endinterface

// *** verilog/nand_bus_cycle.sv ***
// Purpose: Drives one command, address or read cycle on the NAND pins
// Assumes: Chip enable is held low by the caller around the cycle
// Notes:   One clock per write strobe phase, 40 ns each; read strobe held four clocks
`timescale 1ns/1ps
module nand_bus_cycle (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  nand_cycle_if.engine                        cyc,
  output      logic                           cle,
  output      logic                           ale,
  output      logic                           we_n,
  output      logic                           re_n,
  output      logic [nand_lock_pkg::IO_W-1:0] io_out,
  output      logic                           io_oe,
  input  wire logic [nand_lock_pkg::IO_W-1:0] io_in
);

  typedef enum logic [2:0] {
    B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_READ
  } bus_state_t;

  bus_state_t                       state_reg, state_next;
  logic [nand_lock_pkg::CNT_W-1:0]  cnt_reg;
  logic [nand_lock_pkg::IO_W-1:0]   io_meta_reg, io_sync_reg;
  logic                             is_read, read_end;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign is_read  = cyc.kind == nand_lock_pkg::CYC_READ;
  assign read_end = cnt_reg ==
    nand_lock_pkg::CNT_W'(nand_lock_pkg::READ_WAIT_CYC - 1);

  // Two-stage capture of the data pins
  always_ff @(posedge clk) begin
    io_meta_reg <= io_in;
    io_sync_reg <= io_meta_reg;
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      B_IDLE:   if (cyc.req) state_next = is_read ? B_READ : B_SETUP;
      B_SETUP:  state_next = B_STROBE;
      B_STROBE: state_next = B_HOLD;
      B_HOLD:   state_next = B_IDLE;
      B_READ:   if (read_end) state_next = B_IDLE;
      default:  state_next = B_IDLE;
    endcase
  end

  // State and strobe counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= B_IDLE;
      cnt_reg   <= nand_lock_pkg::CNT_RESET_VAL;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == B_READ) ? cnt_reg + 1'b1
                                         : nand_lock_pkg::CNT_RESET_VAL;
    end
  end

  // Latch select and write data for the whole write cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cle    <= 1'b0;
      ale    <= 1'b0;
      io_oe  <= 1'b0;
      io_out <= nand_lock_pkg::DATA_RESET_VAL;
    end else if (state_reg == B_IDLE && cyc.req && !is_read) begin
      cle    <= cyc.kind == nand_lock_pkg::CYC_CMD;
      ale    <= cyc.kind == nand_lock_pkg::CYC_ADDR;
      io_oe  <= 1'b1;
      io_out <= cyc.wdata;
    end else if (state_reg == B_HOLD) begin
      cle   <= 1'b0;
      ale   <= 1'b0;
      io_oe <= 1'b0;
    end
  end

  // Strobes, answer and read capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      we_n      <= nand_lock_pkg::PIN_INACTIVE;
      re_n      <= nand_lock_pkg::PIN_INACTIVE;
      cyc.done  <= 1'b0;
      cyc.rdata <= nand_lock_pkg::DATA_RESET_VAL;
    end else begin
      we_n     <= state_next != B_STROBE;
      re_n     <= !(state_next == B_READ);
      cyc.done <= (state_reg == B_HOLD) ||
                  (state_reg == B_READ && read_end);
      if (state_reg == B_READ && read_end) cyc.rdata <= io_sync_reg;
    end
  end

endmodule

// *** verilog/nand_lock_host.sv ***
// Purpose: Host controller for the block-lock features of a NAND flash
// Assumes: One flash on the bus; ready/busy and I/O come from pins
// Notes:   Accepts one operation at a time on a valid/ready port
`timescale 1ns/1ps

// Summary of operation
// - Lock issues single command 2Ah
// - Unlock sends 23h, start, 24h, end
// - Host orders start not above end
// - Lock-tight issues single command 2Ch
// - Write-protect low pulse relocks every block
// - Lock status read sends 7Ah plus block
// - No lock status read while busy
// - Wait 10 us after power, protect low
module nand_lock_host (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                op_valid,
  output      logic                                op_ready,
  input  wire nand_lock_pkg::op_t                  op_code,
  input  wire logic [nand_lock_pkg::BLK_W-1:0]     start_blk,
  input  wire logic [nand_lock_pkg::BLK_W-1:0]     end_blk,
  input  wire logic                                lock_mode,
  output      logic                                op_done,
  output      logic [nand_lock_pkg::IO_W-1:0]      status_byte,
  output      logic                                ce_n,
  output      logic                                cle,
  output      logic                                ale,
  output      logic                                we_n,
  output      logic                                re_n,
  output      logic                                wp_n,
  output      logic                                pre,
  output      logic [nand_lock_pkg::IO_W-1:0]      io_out,
  output      logic                                io_oe,
  input  wire logic [nand_lock_pkg::IO_W-1:0]      io_in,
  input  wire logic                                ready_busy_n
);

  typedef enum logic [3:0] {
    S_POWER, S_IDLE, S_WAIT_RDY, S_ISSUE, S_WAIT_CYC,
    S_WP_LOW, S_BUSY_GAP, S_BUSY_WAIT, S_DONE
  } host_state_t;

  host_state_t                         state_reg, state_next;
  nand_lock_pkg::op_t                  op_reg;
  logic [nand_lock_pkg::BLK_W-1:0]     lo_blk_reg, hi_blk_reg;
  logic [nand_lock_pkg::STEP_W-1:0]    step_reg;
  logic [nand_lock_pkg::CNT_W-1:0]     cnt_reg;
  logic                                rb_meta_reg, rb_sync_reg;
  logic                                accept, swap_blk, cnt_clear;
  logic                                power_end, wp_end, gap_end;
  nand_lock_pkg::step_t                cur_step;

  nand_cycle_if cyc ();

  // ----------------------------------------------------------------
  // Step table per operation
  // ----------------------------------------------------------------
  function automatic nand_lock_pkg::step_t step_of(
    input nand_lock_pkg::op_t               op,
    input logic [nand_lock_pkg::STEP_W-1:0] step,
    input logic [nand_lock_pkg::BLK_W-1:0]  s,
    input logic [nand_lock_pkg::BLK_W-1:0]  e
  );
    nand_lock_pkg::step_t r;
    r = '{kind: nand_lock_pkg::CYC_CMD,
          data: nand_lock_pkg::CMD_RESET, last: 1'b1};
    case (op)
      nand_lock_pkg::OP_LOCK:
        r.data = nand_lock_pkg::CMD_LOCK;
      nand_lock_pkg::OP_LOCK_TIGHT:
        r.data = nand_lock_pkg::CMD_LOCK_TIGHT;
      nand_lock_pkg::OP_UNLOCK: begin
        r.last = step == 3'h5;
        case (step)
          3'h0: r.data = nand_lock_pkg::CMD_UNLOCK_START;
          3'h1: r = '{nand_lock_pkg::CYC_ADDR, s[7:0], 1'b0};
          3'h2: r = '{nand_lock_pkg::CYC_ADDR, s[15:8], 1'b0};
          3'h3: r.data = nand_lock_pkg::CMD_UNLOCK_END;
          3'h4: r = '{nand_lock_pkg::CYC_ADDR, e[7:0], 1'b0};
          default: r = '{nand_lock_pkg::CYC_ADDR, e[15:8], 1'b1};
        endcase
      end
      nand_lock_pkg::OP_LOCK_STATUS: begin
        r.last = 1'b0;
        case (step)
          3'h0: r.data = nand_lock_pkg::CMD_LOCK_STATUS;
          3'h1: r = '{nand_lock_pkg::CYC_ADDR, s[7:0], 1'b0};
          3'h2: r = '{nand_lock_pkg::CYC_ADDR, s[15:8], 1'b0};
          default: r = '{nand_lock_pkg::CYC_READ, 8'h00, 1'b1};
        endcase
      end
      nand_lock_pkg::OP_STATUS: begin
        r.last = step != 3'h0;
        if (step == 3'h0) r.data = nand_lock_pkg::CMD_STATUS;
        else r.kind = nand_lock_pkg::CYC_READ;
      end
      nand_lock_pkg::OP_STATUS_AGAIN:
        r.kind = nand_lock_pkg::CYC_READ;
      default: r.data = nand_lock_pkg::CMD_RESET;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign op_ready  = state_reg == S_IDLE;
  assign accept    = op_ready && op_valid;
  assign swap_blk  = start_blk > end_blk;
  assign cur_step  = step_of(op_reg, step_reg, lo_blk_reg, hi_blk_reg);
  assign power_end = cnt_reg ==
    nand_lock_pkg::CNT_W'(nand_lock_pkg::POWER_WAIT_CYC - 1);
  assign wp_end    = cnt_reg ==
    nand_lock_pkg::CNT_W'(nand_lock_pkg::WP_PULSE_CYC - 1);
  assign gap_end   = cnt_reg ==
    nand_lock_pkg::CNT_W'(nand_lock_pkg::BUSY_GAP_CYC - 1);
  assign cnt_clear = state_next != state_reg;
  assign cyc.req   = state_reg == S_ISSUE;
  assign cyc.kind  = cur_step.kind;
  assign cyc.wdata = cur_step.data;

  // Ready/busy synchroniser
  always_ff @(posedge clk) begin
    rb_meta_reg <= ready_busy_n;
    rb_sync_reg <= rb_meta_reg;
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_POWER:    if (power_end) state_next = S_IDLE;
      S_IDLE: begin
        if (accept) begin
          if (op_code == nand_lock_pkg::OP_WP_PULSE)
            state_next = S_WP_LOW;
          else if (op_code == nand_lock_pkg::OP_RESET)
            state_next = S_ISSUE;
          else
            state_next = S_WAIT_RDY;
        end
      end
      S_WAIT_RDY: if (rb_sync_reg) state_next = S_ISSUE;
      S_ISSUE:    state_next = S_WAIT_CYC;
      S_WAIT_CYC: begin
        if (cyc.done) begin
          if (!cur_step.last) state_next = S_ISSUE;
          else if (op_reg == nand_lock_pkg::OP_RESET)
            state_next = S_BUSY_GAP;
          else state_next = S_DONE;
        end
      end
      S_WP_LOW:    if (wp_end) state_next = S_DONE;
      S_BUSY_GAP:  if (gap_end) state_next = S_BUSY_WAIT;
      S_BUSY_WAIT: if (rb_sync_reg) state_next = S_DONE;
      S_DONE:      state_next = S_IDLE;
      default:     state_next = S_IDLE;
    endcase
  end

  // State, step and delay counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_POWER;
      step_reg  <= '0;
      cnt_reg   <= nand_lock_pkg::CNT_RESET_VAL;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_clear ? nand_lock_pkg::CNT_RESET_VAL
                             : cnt_reg + 1'b1;
      if (accept) step_reg <= '0;
      else if (state_reg == S_WAIT_CYC && cyc.done)
        step_reg <= step_reg + 1'b1;
    end
  end

  // Operation capture with ordered block range
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg     <= nand_lock_pkg::OP_LOCK;
      lo_blk_reg <= '0;
      hi_blk_reg <= '0;
    end else if (accept) begin
      op_reg     <= op_code;
      lo_blk_reg <= swap_blk ? end_blk : start_blk;
      hi_blk_reg <= swap_blk ? start_blk : end_blk;
    end
  end

  // Control pins, status and completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ce_n        <= nand_lock_pkg::PIN_INACTIVE;
      wp_n        <= nand_lock_pkg::WP_RESET_VAL;
      pre         <= 1'b0;
      op_done     <= 1'b0;
      status_byte <= nand_lock_pkg::DATA_RESET_VAL;
    end else begin
      // Chip enable held low across the read so data follows it
      ce_n    <= !(state_next == S_ISSUE || state_next == S_WAIT_CYC);
      wp_n    <= !(state_next == S_POWER || state_next == S_WP_LOW);
      pre     <= lock_mode;
      op_done <= state_reg == S_DONE;
      if (state_reg == S_WAIT_CYC && cyc.done &&
          cur_step.kind == nand_lock_pkg::CYC_READ)
        status_byte <= cyc.rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------
  nand_bus_cycle u_cycle (
    .clk    (clk),
    .rst_n  (rst_n),
    .cyc    (cyc.engine),
    .cle    (cle),
    .ale    (ale),
    .we_n   (we_n),
    .re_n   (re_n),
    .io_out (io_out),
    .io_oe  (io_oe),
    .io_in  (io_in)
  );

endmodule

// *** dv/nand_lock_host_props.sv ***
// Purpose: Port assertions for the block-lock host
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every host instance
`timescale 1ns/1ps
module nand_lock_host_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       op_ready,
  input wire logic       op_done,
  input wire logic       lock_mode,
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       re_n,
  input wire logic       wp_n,
  input wire logic       pre,
  input wire logic [7:0] io_out,
  input wire logic       io_oe,
  input wire logic       ready_busy_n
);
  // --------------------------------------------------------------
  // Power-up cycle count
  // --------------------------------------------------------------
  localparam int POWER_MIN = 248;
  logic [8:0] up_reg;

  // Cycles since reset release, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) up_reg <= 9'h000;
    else if (up_reg != 9'h1FF) up_reg <= up_reg + 9'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pin behaviour
  AST_RESET_WP: assert property ($rose(rst_n) |-> !wp_n && ce_n)
    else $error("protect not low at reset release");
  AST_POWER_WAIT: assert property (
    (op_ready || wp_n) |-> up_reg >= POWER_MIN)
    else $error("activity before power wait ends");
  AST_PRE_COPY: assert property (
    $stable(lock_mode)[*3] |-> pre == lock_mode)
    else $error("power-on read enable does not follow mode");
  AST_WP_PULSE: assert property (
    $fell(wp_n) |-> (ce_n && !wp_n)[*3] ##1 wp_n)
    else $error("protect pulse length or chip enable wrong");
  AST_READ_STROBE: assert property (
    !re_n |-> !ce_n && we_n && !io_oe && !cle && !ale)
    else $error("read strobe without clean read cycle");
  AST_WRITE_CYCLE: assert property (
    $fell(we_n) |-> !ce_n && (cle != ale) && io_oe
    ##1 we_n && io_oe && $stable(io_out))
    else $error("write cycle malformed");
  AST_DONE_READY: assert property (
    !ready_busy_n && !$past(ready_busy_n, 2) |-> re_n && !op_done)
    else $error("read strobe or completion while flash busy");
  AST_IDLE_PINS: assert property (
    op_ready |-> ce_n && we_n && re_n && !io_oe)
    else $error("bus not idle while ready");
endmodule

bind nand_lock_host nand_lock_host_props u_props (
  .clk(clk), .rst_n(rst_n), .op_ready(op_ready), .op_done(op_done),
  .lock_mode(lock_mode), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .re_n(re_n), .wp_n(wp_n), .pre(pre), .io_out(io_out), .io_oe(io_oe),
  .ready_busy_n(ready_busy_n)
);

// *** dv/nand_flash_model.sv ***
// Purpose: Behavioural flash device with block lock
// Assumes: Cycles latch on the rising write strobe
// Notes:   Status codes are bench choices
`timescale 1ns/1ps
module nand_flash_model #(
  parameter logic [7:0] ST_UNL  = 8'h06,
  parameter logic [7:0] ST_LCK  = 8'h02,
  parameter logic [7:0] ST_TGT  = 8'h01,
  parameter logic [7:0] ST_REG  = 8'hE0,
  parameter int         BUSY_NS = 2000
) (
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic       pre,
  input  wire logic [7:0] host_io,
  output      logic [7:0] dq,
  output      logic       rb_low
);
  // --------------------------------------------------------------
  // Lock state: one unlocked range plus a tight flag
  // --------------------------------------------------------------
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  last = 8'h5A;
  logic [7:0]  st;
  logic [15:0] lo, hi, adr, qb;
  logic        unl_v = 1'b0;
  logic        tight = 1'b0;
  logic        booted = 1'b0;
  logic        rd;
  int          na = 0;
  initial rb_low = 1'b0;

  // Power-on auto page read holds the flash busy once
  always @(posedge pre) begin
    if (!booted) begin
      booted = 1'b1;
      rb_low <= 1'b1;
      rb_low <= #BUSY_NS 1'b0;
    end
  end

  // Protect pulse relocks everything, tight blocks too
  always @(negedge wp_n) begin
    unl_v = 1'b0;
    tight = 1'b0;
  end

  // Command and address cycles
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd = host_io;
      na = 0;
      if (pre && host_io == 8'h2A) unl_v = 1'b0;
      if (pre && host_io == 8'h2C) tight = 1'b1;
      if (host_io == 8'hFF) begin
        cmd = 8'h00;
        rb_low <= 1'b1;
        rb_low <= #BUSY_NS 1'b0;
      end
    end else if (!ce_n && ale) begin
      if (na == 0) adr[7:0] = host_io;
      else adr[15:8] = host_io;
      na = na + 1;
      if (na == 2 && cmd == 8'h23 && pre && !tight) lo = adr;
      if (na == 2 && cmd == 8'h24 && pre && !tight) begin
        hi = adr;
        unl_v = 1'b1;
      end
      if (na == 2) qb = adr;
    end
  end

  // Block state checked against the single range
  assign st = (unl_v && qb >= lo && qb <= hi) ? ST_UNL :
              (tight ? ST_TGT : ST_LCK);
  assign rd = !ce_n && !re_n;

  // Data pins: live status while reading after 70h, or after 7Ah with pre high, else a moving pattern
  always @* begin
    if (rd && cmd == 8'h7A && pre) dq = st;
    else if (rd && cmd == 8'h70) dq = ST_REG;
    else dq = ~last;
  end
  always @(negedge re_n) last = ~last;
endmodule

// *** dv/nand_block_lock_protection_tb_top.sv ***
// Purpose: Self-checking bench for the block-lock host
// Assumes: Flash model answers with the codes below
// Notes:   Expected codes follow the lock rules directly
`timescale 1ns/1ps
module nand_block_lock_protection_tb_top;
  // --------------------------------------------------------------
  // Bench signals
  // --------------------------------------------------------------
  localparam logic [7:0] UNL = 8'h06;
  localparam logic [7:0] LCK = 8'h02;
  localparam logic [7:0] TGT = 8'h01;
  localparam logic [7:0] SREG = 8'hE0;
  localparam int BUSY_NS = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic lock_mode = 1'b1;
  logic seen_busy = 1'b0;
  logic [15:0] start_blk = 16'h0000;
  logic [15:0] end_blk = 16'h0000;
  nand_lock_pkg::op_t op_code = nand_lock_pkg::OP_LOCK;
  logic op_ready, op_done, ce_n, cle, ale, we_n, re_n, wp_n, pre;
  logic io_oe, rb_low, ready_busy_n;
  logic [7:0] status_byte, io_out, io_in, dq;
  int n_mismatch = 0;
  int total_checks = 0;

  // Pull-up on ready/busy; data pins shared with the flash
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
  assign io_in = io_oe ? io_out : dq;
  always #20 clk = ~clk;
  always @(negedge ready_busy_n) seen_busy = 1'b1;

  nand_lock_host dut (
    .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .start_blk(start_blk), .end_blk(end_blk),
    .lock_mode(lock_mode), .op_done(op_done), .status_byte(status_byte),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .pre(pre), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_n(ready_busy_n));

  nand_flash_model #(.ST_UNL(UNL), .ST_LCK(LCK), .ST_TGT(TGT),
    .ST_REG(SREG), .BUSY_NS(BUSY_NS)) flash (
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .pre(pre), .host_io(io_out), .dq(dq), .rb_low(rb_low));

  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_op(input nand_lock_pkg::op_t c,
                        input logic [15:0] s, input logic [15:0] e);
    int i;
    @(negedge clk);
    op_code = c;
    start_blk = s;
    end_blk = e;
    op_valid = 1'b1;
    i = 0;
    while (op_ready !== 1'b1 && i < 5000) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    op_valid = 1'b0;
    i = 0;
    while (op_done !== 1'b1 && i < 5000) begin
      @(negedge clk);
      i++;
    end
    check({7'h00, op_done}, 8'h01);
  endtask

  task automatic blk(input logic [15:0] b, input logic [7:0] exp);
    run_op(nand_lock_pkg::OP_LOCK_STATUS, b, b);
    check(status_byte, exp);
  endtask

  // Scenarios
  task automatic t_power;
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 400) begin
      if (n == 200) check({7'h00, wp_n}, 8'h00);
      @(negedge clk);
      n++;
    end
    check({7'h00, n >= 249}, 8'h01);
    check({7'h00, pre}, 8'h01);
    blk(16'h0005, LCK);
  endtask

  task automatic t_unlock;
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h0003, 16'h0007);
    blk(16'h0003, UNL);
    blk(16'h0007, UNL);
    blk(16'h0002, LCK);
    blk(16'h0008, LCK);
    run_op(nand_lock_pkg::OP_STATUS_AGAIN, 16'h0007, 16'h0007);
    check(status_byte, LCK);
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h0007, 16'h0003);
    blk(16'h0005, UNL);
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h0014, 16'h0014);
    blk(16'h0014, UNL);
    blk(16'h0005, LCK);
  endtask

  task automatic t_bounds;
    logic [63:0] tab [5] = '{{16'h0000, 16'hFFFF, 16'h1234, 8'h00, UNL},
      {16'hFFFF, 16'hFFFF, 16'hFFFF, 8'h00, UNL},
      {16'hFFFF, 16'hFFFF, 16'hFFFE, 8'h00, LCK},
      {16'h0000, 16'h0000, 16'h0000, 8'h00, UNL},
      {16'h0000, 16'h0000, 16'h0001, 8'h00, LCK}};
    foreach (tab[i]) begin
      run_op(nand_lock_pkg::OP_UNLOCK, tab[i][63:48], tab[i][47:32]);
      blk(tab[i][31:16], tab[i][7:0]);
    end
    run_op(nand_lock_pkg::OP_LOCK, 16'h0000, 16'h0000);
    blk(16'h0000, LCK);
  endtask

  task automatic t_tight;
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h000A, 16'h0014);
    run_op(nand_lock_pkg::OP_LOCK_TIGHT, 16'h0000, 16'h0000);
    blk(16'h000F, UNL);
    blk(16'h001E, TGT);
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h001E, 16'h001E);
    blk(16'h001E, TGT);
    blk(16'h000F, UNL);
    run_op(nand_lock_pkg::OP_WP_PULSE, 16'h0000, 16'h0000);
    blk(16'h001E, LCK);
    blk(16'h000F, LCK);
  endtask

  task automatic t_reset;
    realtime t0;
    seen_busy = 1'b0;
    t0 = $realtime;
    run_op(nand_lock_pkg::OP_RESET, 16'h0000, 16'h0000);
    check({7'h00, seen_busy}, 8'h01);
    check({7'h00, ready_busy_n}, 8'h01);
    check({7'h00, ($realtime - t0) >= BUSY_NS}, 8'h01);
  endtask

  task automatic t_plain;
    lock_mode = 1'b0;
    repeat (4) @(negedge clk);
    check({7'h00, pre}, 8'h00);
    run_op(nand_lock_pkg::OP_STATUS, 16'h0000, 16'h0000);
    check(status_byte, SREG);
    run_op(nand_lock_pkg::OP_UNLOCK, 16'h0000, 16'hFFFF);
    lock_mode = 1'b1;
    repeat (4) @(negedge clk);
    blk(16'h0040, LCK);
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_power();
    t_unlock();
    t_bounds();
    t_tight();
    t_reset();
    t_plain();
    finish_test();
  end

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
endmodule
